// file: core/sgc_bank.sv
/*
 * Switch global control bank: two byte-wide configuration registers and the
 * policy decisions that they steer in the switch core.
 * Assumes a simple synchronous management register port and that every input
 * but the asynchronous reset rst_i is synchronous to clk_i. The frame size strap is sampled on the first edge
 * after reset release.
 */
//
// Operation
// RQ1: Pass-all bit with sniffer mode forwards every frame, errored ones too.
// RQ2: Transmit pause bit clear means no PAUSE frame is ever generated.
// RQ3: Receive pause bit clear means received PAUSE frames are ignored.
// RQ4: Length check drops frames whose Length/Type below 1500 mismatches length.
// RQ5: Address aging runs only while the aging enable bit is one.
// RQ6: Fast-age bit switches aging to the fast period of about 800us.
// RQ7: Aggressive back-off bit selects the non-standard half duplex back-off.
// RQ8: Discard bit set blocks VLAN crossing; clear lets known unicast cross.
// RQ9: Port mirroring is unsupported while the discard bit is clear.
// RQ10: Storm protection polices broadcast only, or also DA[40] when cleared.
// RQ11: Backpressure is carrier-sense based at one, collision based at zero.
// RQ12: Fair mode drops non flow controlled traffic, else throttles flow controlled.
// RQ13: Bit 3 clear drops packets after 16 or more collisions.
// RQ14: Huge bit accepts frames up to 1916 bytes, overriding the size check.
// RQ15: Size check off allows 1536; on allows 1522 tagged, 1518 untagged.
// RQ16: Priority reserve with multiple queues reserves 48 buffers for queues 3-1.
// RQ17: Software should set priority reserve when multiple queues are used.
// RQ18: After one fast aging cycle the timer returns to the 200 s period.
// RQ19: Legal size check reset value comes from the frame size strap pin.
`timescale 1ns/1ns
`default_nettype none

module sgc_bank #(
   parameter logic [sgc_pkg::AGE_CNT_W-1:0] FAST_AGE_CYC = sgc_pkg::FAST_AGE_CYC,
   parameter logic [sgc_pkg::AGE_CNT_W-1:0] NORM_AGE_CYC = sgc_pkg::NORM_AGE_CYC
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Management register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   output logic             reg_rvalid_o,
   // Strap
   input  wire logic        frame_size_strap_pin_i,
   // Frame acceptance
   input  wire logic        frame_done_i,
   input  wire logic [11:0] frame_len_i,
   input  wire logic [11:0] frame_payload_len_i,
   input  wire logic [15:0] frame_len_type_i,
   input  wire logic        frame_tagged_i,
   input  wire logic        frame_bad_i,
   input  wire logic        sniffer_mode_i,
   output logic             frame_checked_o,
   output logic             frame_drop_o,
   // Flow control
   input  wire logic        pause_req_i,
   input  wire logic        pause_rx_i,
   output logic             pause_tx_o,
   output logic             pause_honor_o,
   // MAC half duplex
   input  wire logic [4:0]  coll_cnt_i,
   output logic             coll_drop_o,
   output logic             aggr_backoff_o,
   output logic             bp_carrier_sense_o,
   // Forwarding policy
   input  wire logic        same_vlan_i,
   input  wire logic        known_unicast_i,
   input  wire logic        mirror_req_i,
   input  wire logic        da_bcast_i,
   input  wire logic        da_bit40_i,
   input  wire logic        fc_contention_i,
   input  wire logic        multi_queue_i,
   output logic             vlan_cross_ok_o,
   output logic             mirror_en_o,
   output logic             storm_police_o,
   output logic             fair_drop_o,
   output logic             fc_throttle_o,
   output logic             reserve_hi_o,
   // Aging
   output logic             age_tick_o,
   output logic             fast_age_active_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] gc1;
      logic [7:0] gc2;
      logic       init_done;
      logic [7:0] rdata;
      logic       rvalid;
      logic       checked;
      logic       drop;
      logic       pause_tx;
      logic       pause_honor;
      logic       coll_drop;
      logic       vlan_ok;
      logic       mirror;
      logic       storm;
      logic       fair_drop;
      logic       throttle;
      logic       reserve;
   } sgc_state_t;

   localparam sgc_state_t ST_RST = '{
      gc1: sgc_pkg::GC_ONE_RST, gc2: sgc_pkg::GC_TWO_RST, rdata: sgc_pkg::RDATA_NONE,
      default: 1'b0};

   sgc_state_t st_q;
   sgc_state_t st_d;
   logic       wr_gc1;
   logic       wr_gc2;
   logic       fc_drop;

   assign wr_gc1 = st_q.init_done && reg_wr_i && (reg_addr_i == sgc_pkg::ADDR_GC_ONE);
   assign wr_gc2 = st_q.init_done && reg_wr_i && (reg_addr_i == sgc_pkg::ADDR_GC_TWO);

   // ----------------------------------------------------------------
   // Frame check and aging
   // ----------------------------------------------------------------
   sgc_frame_check u_frame_check (
      .len_chk_en_i  (st_q.gc1[sgc_pkg::G1_LEN_CHECK]),
      .huge_en_i     (st_q.gc2[sgc_pkg::G2_HUGE_PKT]),
      .legal_en_i    (st_q.gc2[sgc_pkg::G2_LEGAL_SIZE]),
      .pass_all_i    (st_q.gc1[sgc_pkg::G1_PASS_ALL] && sniffer_mode_i),  // RQ1
      .len_type_i    (frame_len_type_i),
      .frame_len_i   (frame_len_i),
      .payload_len_i (frame_payload_len_i),
      .tagged_i      (frame_tagged_i),
      .bad_i         (frame_bad_i),
      .drop_o        (fc_drop)
   );

   sgc_age_timer #(
      .FAST_CYC (FAST_AGE_CYC),
      .NORM_CYC (NORM_AGE_CYC)
   ) u_age_timer (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .enable_i      (st_q.gc1[sgc_pkg::G1_AGE_EN]),  // RQ5
      .fast_arm_i    (wr_gc1 && reg_wdata_i[sgc_pkg::G1_FAST_AGE]),  // RQ6
      .age_tick_o    (age_tick_o),
      .fast_active_o (fast_age_active_o)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      if (!st_q.init_done) begin
         st_d.init_done = 1'b1;
         st_d.gc2[sgc_pkg::G2_LEGAL_SIZE] = frame_size_strap_pin_i;  // RQ19
      end
      if (wr_gc1) begin
         st_d.gc1 = reg_wdata_i;
      end
      if (wr_gc2) begin
         st_d.gc2 = reg_wdata_i;
      end
      st_d.rvalid = reg_rd_i;
      if (!reg_rd_i) begin
         st_d.rdata = st_q.rdata;
      end else if (reg_addr_i == sgc_pkg::ADDR_GC_ONE) begin
         st_d.rdata = st_q.gc1;
      end else if (reg_addr_i == sgc_pkg::ADDR_GC_TWO) begin
         st_d.rdata = st_q.gc2;
      end else begin
         st_d.rdata = sgc_pkg::RDATA_NONE;
      end
      st_d.checked     = frame_done_i;
      st_d.drop        = frame_done_i && fc_drop;
      st_d.pause_tx    = pause_req_i && st_q.gc1[sgc_pkg::G1_TX_PAUSE];  // RQ2
      st_d.pause_honor = pause_rx_i && st_q.gc1[sgc_pkg::G1_RX_PAUSE];  // RQ3
      st_d.coll_drop   = (coll_cnt_i >= sgc_pkg::COLL_LIMIT)
                         && !st_q.gc2[sgc_pkg::G2_NO_COLL_DR];  // RQ13
      st_d.vlan_ok     = same_vlan_i || (known_unicast_i
                         && !st_q.gc2[sgc_pkg::G2_VLAN_DISC]);  // RQ8
      st_d.mirror      = mirror_req_i && st_q.gc2[sgc_pkg::G2_VLAN_DISC];  // RQ9
      st_d.storm       = da_bcast_i || (da_bit40_i
                         && !st_q.gc2[sgc_pkg::G2_MCAST_EXCL]);  // RQ10
      st_d.fair_drop   = fc_contention_i && st_q.gc2[sgc_pkg::G2_FAIR_MODE];  // RQ12
      st_d.throttle    = fc_contention_i && !st_q.gc2[sgc_pkg::G2_FAIR_MODE];  // RQ12
      st_d.reserve     = multi_queue_i && st_q.gc2[sgc_pkg::G2_PRIO_RSV];  // RQ16
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o        = st_q.rdata;
   assign reg_rvalid_o       = st_q.rvalid;
   assign frame_checked_o    = st_q.checked;
   assign frame_drop_o       = st_q.drop;
   assign pause_tx_o         = st_q.pause_tx;
   assign pause_honor_o      = st_q.pause_honor;
   assign coll_drop_o        = st_q.coll_drop;
   assign aggr_backoff_o     = st_q.gc1[sgc_pkg::G1_AGGR_BOFF];  // RQ7
   assign bp_carrier_sense_o = st_q.gc2[sgc_pkg::G2_BP_CARRIER];  // RQ11
   assign vlan_cross_ok_o    = st_q.vlan_ok;
   assign mirror_en_o        = st_q.mirror;
   assign storm_police_o     = st_q.storm;
   assign fair_drop_o        = st_q.fair_drop;
   assign fc_throttle_o      = st_q.throttle;
   assign reserve_hi_o       = st_q.reserve;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_strap_load;
      !st_q.init_done ##1 st_q.init_done;
   endsequence

   sequence s_gc1_write;
      reg_wr_i && st_q.init_done && (reg_addr_i == sgc_pkg::ADDR_GC_ONE) ##1 reg_rd_i
      && (reg_addr_i == sgc_pkg::ADDR_GC_ONE);
   endsequence

   a_strap_capture: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ19
      s_strap_load |-> st_q.gc2[sgc_pkg::G2_LEGAL_SIZE] == $past(frame_size_strap_pin_i))
      else $error("strap not captured into size check bit");

   a_gc1_readback: assert property (@(posedge clk_i) disable iff (rst_i)
      s_gc1_write |=> reg_rvalid_o && (reg_rdata_o == $past(reg_wdata_i, 2)))
      else $error("register readback mismatch");

   a_pause_tx_gate: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ2
      pause_tx_o |-> $past(pause_req_i) && $past(st_q.gc1[sgc_pkg::G1_TX_PAUSE]))
      else $error("pause frame generated while disabled");

   a_pause_rx_gate: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ3
      $past(pause_rx_i) |-> pause_honor_o == $past(st_q.gc1[sgc_pkg::G1_RX_PAUSE]))
      else $error("received pause handling wrong");

   a_pass_all_frame: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ1
      (frame_checked_o && $past(st_q.gc1[sgc_pkg::G1_PASS_ALL] && sniffer_mode_i))
      |-> !frame_drop_o)
      else $error("frame dropped in pass-all mode");

   a_len_mismatch: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ4
      (frame_checked_o && $past(st_q.gc1[sgc_pkg::G1_LEN_CHECK] && !sniffer_mode_i
      && frame_len_type_i < sgc_pkg::LEN_TYPE_LIMIT
      && frame_len_type_i != {4'h0, frame_payload_len_i})) |-> frame_drop_o)
      else $error("length field mismatch not dropped");

   a_huge_accept: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ14
      (frame_checked_o && $past(st_q.gc2[sgc_pkg::G2_HUGE_PKT] && !frame_bad_i
      && !st_q.gc1[sgc_pkg::G1_LEN_CHECK] && frame_len_i <= sgc_pkg::SIZE_HUGE))
      |-> !frame_drop_o)
      else $error("huge frame wrongly dropped");

   a_untag_limit: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ15
      (frame_checked_o && $past(!st_q.gc2[sgc_pkg::G2_HUGE_PKT] && !sniffer_mode_i
      && st_q.gc2[sgc_pkg::G2_LEGAL_SIZE] && !frame_tagged_i
      && frame_len_i > sgc_pkg::SIZE_UNTAGGED)) |-> frame_drop_o)
      else $error("oversize untagged frame accepted");

   a_vlan_cross: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ8
      (vlan_cross_ok_o && !$past(same_vlan_i))
      |-> $past(known_unicast_i && !st_q.gc2[sgc_pkg::G2_VLAN_DISC]))
      else $error("packet crossed VLAN boundary");

   a_mirror_block: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ9
      mirror_en_o |-> $past(st_q.gc2[sgc_pkg::G2_VLAN_DISC]))
      else $error("mirroring with discard bit clear");

   a_storm_scope: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ10
      $past(da_bit40_i && !da_bcast_i)
      |-> storm_police_o == !$past(st_q.gc2[sgc_pkg::G2_MCAST_EXCL]))
      else $error("storm policing scope wrong");

   a_fair_choice: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ12
      $past(fc_contention_i) |-> (fair_drop_o != fc_throttle_o)
      && (fair_drop_o == $past(st_q.gc2[sgc_pkg::G2_FAIR_MODE])))
      else $error("fair mode choice wrong");

   a_coll_drop: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ13
      coll_drop_o |-> $past(coll_cnt_i >= sgc_pkg::COLL_LIMIT)
      && !$past(st_q.gc2[sgc_pkg::G2_NO_COLL_DR]))
      else $error("collision drop condition wrong");

   a_prio_reserve: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ16
      reserve_hi_o |-> $past(multi_queue_i) && $past(st_q.gc2[sgc_pkg::G2_PRIO_RSV]))
      else $error("buffer reserve without multiple queues");

endmodule : sgc_bank

`default_nettype wire

// file: core/sgc_pkg.sv
/*
 * Constants for the switch global control bank: register offsets, field positions,
 * reset values, frame size limits and aging periods.
 * Assumes a 50 MHz core clock.
 */
`default_nettype none

package sgc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_GC_ONE = 8'h03;
   localparam logic [7:0] ADDR_GC_TWO = 8'h04;

   // Reset values; bit 1 of the second register is replaced by the strap
   localparam logic [7:0] GC_ONE_RST  = 8'h30;
   localparam logic [7:0] GC_TWO_RST  = 8'hF1;
   localparam logic [7:0] RDATA_NONE  = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int G1_PASS_ALL   = 7;
   localparam int G1_TX_PAUSE   = 5;
   localparam int G1_RX_PAUSE   = 4;
   localparam int G1_LEN_CHECK  = 3;
   localparam int G1_AGE_EN     = 2;
   localparam int G1_FAST_AGE   = 1;
   localparam int G1_AGGR_BOFF  = 0;
   localparam int G2_VLAN_DISC  = 7;
   localparam int G2_MCAST_EXCL = 6;
   localparam int G2_BP_CARRIER = 5;
   localparam int G2_FAIR_MODE  = 4;
   localparam int G2_NO_COLL_DR = 3;
   localparam int G2_HUGE_PKT   = 2;
   localparam int G2_LEGAL_SIZE = 1;
   localparam int G2_PRIO_RSV   = 0;

   // ----------------------------------------------------------------
   // Frame limits
   // ----------------------------------------------------------------
   localparam logic [15:0] LEN_TYPE_LIMIT = 16'h05DC;  // 1500
   localparam logic [11:0] SIZE_HUGE      = 12'h77C;   // 1916
   localparam logic [11:0] SIZE_STD       = 12'h600;   // 1536
   localparam logic [11:0] SIZE_TAGGED    = 12'h5F2;   // 1522
   localparam logic [11:0] SIZE_UNTAGGED  = 12'h5EE;   // 1518
   localparam logic [4:0]  COLL_LIMIT     = 5'h10;     // 16

   // ----------------------------------------------------------------
   // Aging periods
   // ----------------------------------------------------------------
   localparam int          AGE_CNT_W    = 34;
   localparam longint      CLK_HZ       = 50_000_000;
   localparam longint      FAST_AGE_US  = 800;
   localparam longint      NORM_AGE_S   = 200;
   localparam logic [AGE_CNT_W-1:0] FAST_AGE_CYC =
      AGE_CNT_W'(FAST_AGE_US * CLK_HZ / 1_000_000);
   localparam logic [AGE_CNT_W-1:0] NORM_AGE_CYC =
      AGE_CNT_W'(NORM_AGE_S * CLK_HZ);

endpackage : sgc_pkg

`default_nettype wire

// file: core/sgc_frame_check.sv
/*
 * Frame acceptance decision: length field check, maximum size check and
 * pass-all override. Purely combinational.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ns
`default_nettype none

module sgc_frame_check (
   // Controls
   input  wire logic        len_chk_en_i,
   input  wire logic        huge_en_i,
   input  wire logic        legal_en_i,
   input  wire logic        pass_all_i,
   // Frame
   input  wire logic [15:0] len_type_i,
   input  wire logic [11:0] frame_len_i,
   input  wire logic [11:0] payload_len_i,
   input  wire logic        tagged_i,
   input  wire logic        bad_i,
   // Decision
   output logic             drop_o
);

   logic [11:0] max_len;
   logic        oversize;
   logic        len_mismatch;

   always_comb begin
      if (huge_en_i) begin
         max_len = sgc_pkg::SIZE_HUGE;  // RQ14
      end else if (legal_en_i) begin
         max_len = tagged_i ? sgc_pkg::SIZE_TAGGED : sgc_pkg::SIZE_UNTAGGED;  // RQ15
      end else begin
         max_len = sgc_pkg::SIZE_STD;  // RQ15
      end
      oversize     = frame_len_i > max_len;
      len_mismatch = len_chk_en_i && (len_type_i < sgc_pkg::LEN_TYPE_LIMIT)
                     && (len_type_i != {4'h0, payload_len_i});  // RQ4
      drop_o       = !pass_all_i && (bad_i || oversize || len_mismatch);  // RQ1
   end

endmodule : sgc_frame_check

`default_nettype wire

// file: core/sgc_age_timer.sv
/*
 * Address table aging period timer with a one-shot fast period.
 * Assumes fast_arm_i pulses when software writes the fast-age bit as one.
 */
`timescale 1ns/1ns
`default_nettype none

module sgc_age_timer #(
   parameter logic [sgc_pkg::AGE_CNT_W-1:0] FAST_CYC = sgc_pkg::FAST_AGE_CYC,
   parameter logic [sgc_pkg::AGE_CNT_W-1:0] NORM_CYC = sgc_pkg::NORM_AGE_CYC
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control
   input  wire logic enable_i,
   input  wire logic fast_arm_i,
   // Status
   output logic      age_tick_o,
   output logic      fast_active_o
);

   typedef struct packed {
      logic [sgc_pkg::AGE_CNT_W-1:0] cnt;
      logic                          fast;
      logic                          tick;
   } sgc_age_t;

   sgc_age_t st_q;
   sgc_age_t st_d;
   logic [sgc_pkg::AGE_CNT_W-1:0] limit;

   always_comb begin
      st_d     = st_q;
      st_d.tick = 1'b0;
      limit    = st_q.fast ? FAST_CYC : NORM_CYC;  // RQ6
      if (enable_i) begin  // RQ5
         if (st_q.cnt >= limit - 1'b1) begin
            st_d.cnt  = '0;
            st_d.tick = 1'b1;
            st_d.fast = 1'b0;  // RQ18
         end else begin
            st_d.cnt = st_q.cnt + 1'b1;
         end
      end
      if (fast_arm_i) begin
         st_d.fast = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign age_tick_o    = st_q.tick;
   assign fast_active_o = st_q.fast;

   a_age_halted: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ5
      !enable_i |=> (st_q.cnt == $past(st_q.cnt)) && !age_tick_o)
      else $error("aging advanced while disabled");

   a_fast_period: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ6
      (enable_i && st_q.fast && st_q.cnt >= FAST_CYC - 1'b1) |=> age_tick_o)
      else $error("fast age period wrong");

   a_tick_early: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ6
      age_tick_o |-> $past(st_q.cnt) >= ($past(st_q.fast) ? FAST_CYC : NORM_CYC) - 1'b1)
      else $error("aging period ended early");

   a_fast_revert: assert property (@(posedge clk_i) disable iff (rst_i)  // RQ18
      (age_tick_o && !$past(fast_arm_i)) |-> !fast_active_o)
      else $error("fast aging did not revert after one cycle");

endmodule : sgc_age_timer

`default_nettype wire

// file: verification/test_switch_global_control_bank.sv
/*
 * Self-checking testbench for the switch global control bank.
 * Assumes one-cycle register and policy timing, with aging periods
 * shortened to 20 and 50 cycles.
 */
`timescale 1ns/1ns
`default_nettype none

module test_switch_global_control_bank;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam logic [sgc_pkg::AGE_CNT_W-1:0] FAST_CYC = 34'h14;
   localparam logic [sgc_pkg::AGE_CNT_W-1:0] NORM_CYC = 34'h32;

   typedef struct packed {
      logic [7:0]  g1;
      logic [7:0]  g2;
      logic [13:0] pin;
      logic [10:0] pout;
      logic        sniff;
      logic        tag;
      logic        bad;
      logic [11:0] len;
      logic [11:0] pay;
      logic [15:0] lt;
      logic        drop;
   } sgc_row_t;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  reg_addr_i = 8'h00;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic [7:0]  reg_rdata_o;
   logic        reg_rvalid_o;
   logic        frame_size_strap_pin_i = 1'b1;
   logic        frame_done_i = 1'b0;
   logic [11:0] frame_len_i = 12'h000;
   logic [11:0] frame_payload_len_i = 12'h000;
   logic [15:0] frame_len_type_i = 16'h0000;
   logic        frame_tagged_i = 1'b0;
   logic        frame_bad_i = 1'b0;
   logic        sniffer_mode_i = 1'b0;
   logic        frame_checked_o, frame_drop_o;
   logic        pause_req_i = 1'b0, pause_rx_i = 1'b0;
   logic        pause_tx_o, pause_honor_o;
   logic [4:0]  coll_cnt_i = 5'h00;
   logic        coll_drop_o, aggr_backoff_o, bp_carrier_sense_o;
   logic        same_vlan_i = 1'b0, known_unicast_i = 1'b0, mirror_req_i = 1'b0;
   logic        da_bcast_i = 1'b0, da_bit40_i = 1'b0, fc_contention_i = 1'b0;
   logic        multi_queue_i = 1'b0;
   logic        vlan_cross_ok_o, mirror_en_o, storm_police_o, fair_drop_o;
   logic        fc_throttle_o, reserve_hi_o, age_tick_o, fast_age_active_o;
   int          bad_count = 0;
   int          num_checks = 0;
   int          n;
   sgc_row_t    r;

   // Ordinary cases: policy outputs and frame acceptance
   sgc_row_t rows [21] = '{
      '{8'h30, 8'hF3, 14'h3837, 11'h755, 1'b0, 1'b0, 1'b0, 12'h040, 12'h02E, 16'h0800, 1'b0},
      '{8'h01, 8'h08, 14'h3FB7, 11'h0AA, 1'b0, 1'b0, 1'b0, 12'h040, 12'h02E, 16'h0800, 1'b0},
      '{8'h01, 8'h00, 14'h07C8, 11'h0A8, 1'b0, 1'b0, 1'b0, 12'h040, 12'h02E, 16'h0800, 1'b0},
      '{8'h30, 8'h00, 14'h2800, 11'h500, 1'b0, 1'b0, 1'b0, 12'h040, 12'h02E, 16'h0800, 1'b0},
      '{8'h00, 8'h04, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b0, 12'h77C, 12'h02E, 16'h0800, 1'b0},
      '{8'h00, 8'h04, 14'h0000, 11'h000, 1'b0, 1'b1, 1'b0, 12'h77D, 12'h02E, 16'h0800, 1'b1},
      '{8'h00, 8'h02, 14'h0000, 11'h000, 1'b0, 1'b1, 1'b0, 12'h5F2, 12'h02E, 16'h0800, 1'b0},
      '{8'h00, 8'h02, 14'h0000, 11'h000, 1'b0, 1'b1, 1'b0, 12'h5F3, 12'h02E, 16'h0800, 1'b1},
      '{8'h00, 8'h02, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b0, 12'h5EE, 12'h02E, 16'h0800, 1'b0},
      '{8'h00, 8'h02, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b0, 12'h5EF, 12'h02E, 16'h0800, 1'b1},
      '{8'h00, 8'h00, 14'h0000, 11'h000, 1'b0, 1'b1, 1'b0, 12'h600, 12'h02E, 16'h0800, 1'b0},
      '{8'h00, 8'h00, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b0, 12'h601, 12'h02E, 16'h0800, 1'b1},
      '{8'h08, 8'h00, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b0, 12'h0C8, 12'h063, 16'h0064, 1'b1},
      '{8'h08, 8'h00, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b0, 12'h0C8, 12'h064, 16'h0064, 1'b0},
      '{8'h08, 8'h00, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b0, 12'h0C8, 12'h00A, 16'h05DC, 1'b0},
      '{8'h08, 8'h00, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b0, 12'h0C8, 12'h00A, 16'h05DB, 1'b1},
      '{8'h00, 8'h00, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b0, 12'h0C8, 12'h063, 16'h0064, 1'b0},
      '{8'h00, 8'h00, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b1, 12'h040, 12'h02E, 16'h0800, 1'b1},
      '{8'h80, 8'h00, 14'h0000, 11'h000, 1'b1, 1'b0, 1'b1, 12'h040, 12'h02E, 16'h0800, 1'b0},
      '{8'h80, 8'h00, 14'h0000, 11'h000, 1'b0, 1'b0, 1'b1, 12'h040, 12'h02E, 16'h0800, 1'b1},
      '{8'h80, 8'h00, 14'h0000, 11'h000, 1'b1, 1'b0, 1'b0, 12'h601, 12'h02E, 16'h0800, 1'b0}
   };

   always #10 clk_i = ~clk_i;

   sgc_bank #(.FAST_AGE_CYC(FAST_CYC), .NORM_AGE_CYC(NORM_CYC)) i_dut (.*);

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, seen, exp);
      end
   endtask : chk

   // Strobe stays high for back-to-back writes; rd lowers it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
      @(negedge clk_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      {reg_addr_i, reg_wr_i, reg_rd_i} = {a, 1'b0, 1'b1};
      @(negedge clk_i);
      reg_rd_i = 1'b0;
      chk(16'(reg_rvalid_o), 16'h0001, "read valid");
      chk(16'(reg_rdata_o), 16'(exp), "read data");
      @(negedge clk_i);
   endtask : rd

   // Counts cycles up to the next aging tick, bounded by lim
   task automatic wait_tick(input int lim, output int cnt);
      cnt = 0;
      do begin
         @(negedge clk_i);
         cnt++;
         if (cnt > lim) begin
            chk(16'h0000, 16'h0001, "tick timeout");
            test_done();
         end
      end while (age_tick_o !== 1'b1);
   endtask : wait_tick

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(negedge clk_i);
      chk(16'({reg_rvalid_o, frame_checked_o, pause_tx_o}), 16'h0000, "outputs in reset");
      rst_i = 1'b0;
      wr(sgc_pkg::ADDR_GC_ONE, 8'hFF);
      rd(sgc_pkg::ADDR_GC_ONE, sgc_pkg::GC_ONE_RST);
      rd(sgc_pkg::ADDR_GC_TWO, 8'hF3);
      chk(16'(bp_carrier_sense_o), 16'h0001, "carrier sense default");
      wr(8'h05, 8'hFF);
      rd(8'h05, sgc_pkg::RDATA_NONE);
      rd(sgc_pkg::ADDR_GC_ONE, sgc_pkg::GC_ONE_RST);
      chk(16'(reg_rvalid_o), 16'h0000, "valid one cycle");
      $display("test reset_and_map done");

      for (int i = 0; i < 21; i++) begin
         r = rows[i];
         wr(sgc_pkg::ADDR_GC_ONE, r.g1);
         wr(sgc_pkg::ADDR_GC_TWO, r.g2);
         rd(sgc_pkg::ADDR_GC_TWO, r.g2);
         {pause_req_i, pause_rx_i, coll_cnt_i, same_vlan_i, known_unicast_i, mirror_req_i,
          da_bcast_i, da_bit40_i, fc_contention_i, multi_queue_i} = r.pin;
         {sniffer_mode_i, frame_tagged_i, frame_bad_i} = {r.sniff, r.tag, r.bad};
         {frame_len_i, frame_payload_len_i, frame_len_type_i} = {r.len, r.pay, r.lt};
         frame_done_i = 1'b1;
         @(negedge clk_i);
         frame_done_i = 1'b0;
         chk(16'({pause_tx_o, pause_honor_o, coll_drop_o, aggr_backoff_o,
                  bp_carrier_sense_o, vlan_cross_ok_o, mirror_en_o,
                  storm_police_o, fair_drop_o, fc_throttle_o,
                  reserve_hi_o}), 16'(r.pout), "policy");
         chk(16'({frame_checked_o, frame_drop_o}), 16'({1'b1, r.drop}), "frame");
      end
      $display("test table done");

      n = 0;
      repeat (120) begin
         @(negedge clk_i);
         if (age_tick_o === 1'b1)
            n++;
      end
      chk(16'(n), 16'h0000, "aging halted");
      wr(sgc_pkg::ADDR_GC_ONE, 8'h04);
      rd(sgc_pkg::ADDR_GC_ONE, 8'h04);
      wait_tick(60, n);
      wait_tick(60, n);
      chk(16'(n), 16'h0032, "normal period");
      wr(sgc_pkg::ADDR_GC_ONE, 8'h06);
      rd(sgc_pkg::ADDR_GC_ONE, 8'h06);
      chk(16'(fast_age_active_o), 16'h0001, "fast armed");
      wait_tick(60, n);
      chk(16'(n >= 15 && n <= 20), 16'h0001, "fast period");
      chk(16'(fast_age_active_o), 16'h0000, "fast ends");
      wait_tick(60, n);
      chk(16'(n), 16'h0032, "back to normal");
      $display("test aging done");

      rst_i = 1'b1;
      frame_size_strap_pin_i = 1'b0;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      @(negedge clk_i);
      rd(sgc_pkg::ADDR_GC_TWO, 8'hF1);
      $display("test second_reset done");
      test_done();
   end

endmodule : test_switch_global_control_bank

`default_nettype wire
